// [pmh_host_pins.sv]
// Host-side model that drives the hard reset and emergency unload pins.
`timescale 1ns/1ps
module pmh_host_pins
(
   input  wire logic clk,
   input  wire logic emerg_req,
   input  wire logic hrst_req,
   output logic      hard_reset_pin_n,
   output logic      emerg_unload_pin
);
   logic [3:0] emerg_cnt = 4'h0;
   logic [3:0] hrst_cnt  = 4'h0;
   // Pulses last eight cycles so the pin synchroniser sees a settled edge.
   always_ff @(posedge clk)
   begin
      emerg_cnt <= emerg_req ? 4'h8 :
                   (emerg_cnt != 4'h0) ? emerg_cnt - 4'h1 : 4'h0;
      hrst_cnt  <= hrst_req ? 4'h8 :
                   (hrst_cnt != 4'h0) ? hrst_cnt - 4'h1 : 4'h0;
   end
   assign emerg_unload_pin = (emerg_cnt != 4'h0);
   assign hard_reset_pin_n = (hrst_cnt == 4'h0);
endmodule

// [pmh_pkg.sv]
// Shared constants and types for the drive power mode and health monitor.
package pmh_pkg;

   // Clock and the millisecond time base.
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   // Times, in their own units, and the millisecond counts derived from them.
   localparam int unsigned AI_WAKE_MS    = 20;
   localparam int unsigned LP_WAKE_MS    = 300;
   localparam int unsigned SPINUP_MS     = 2000;
   localparam int unsigned AUTOSAVE_MIN  = 30;
   localparam int unsigned DEF_TIMER_MIN = 109;
   localparam int unsigned TIMER_UNIT_MS = 5000;
   localparam int unsigned AVG_INIT_MS   = 1000;
   localparam int unsigned MS_PER_MIN    = 60000;

   localparam logic [11:0] AI_WAKE     = 12'(AI_WAKE_MS);
   localparam logic [11:0] LP_WAKE     = 12'(LP_WAKE_MS);
   localparam logic [11:0] SPINUP_WAKE = 12'(SPINUP_MS);
   localparam logic [23:0] AUTOSAVE_MS = 24'(AUTOSAVE_MIN * MS_PER_MIN);
   localparam logic [23:0] DEF_TIMER   = 24'(DEF_TIMER_MIN * MS_PER_MIN);
   localparam logic [23:0] TIMER_UNIT  = 24'(TIMER_UNIT_MS);
   localparam logic [23:0] AVG_INIT    = 24'(AVG_INIT_MS);

   // Register byte addresses.
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam logic [7:0] ADDR_ID83   = 8'h08;
   localparam logic [7:0] ADDR_ID86   = 8'h0C;
   localparam logic [7:0] ADDR_ID91   = 8'h10;
   localparam logic [7:0] ADDR_SAVES  = 8'h14;
   localparam logic [7:0] ADDR_THR    = 8'h18;
   localparam logic [3:0] ATTR_PAGE   = 4'h2;

   // Command codes written to the low nibble of the command register.
   localparam logic [3:0] CMD_APM_EN   = 4'h1;
   localparam logic [3:0] CMD_APM_DIS  = 4'h2;
   localparam logic [3:0] CMD_IDLE     = 4'h3;
   localparam logic [3:0] CMD_STBY     = 4'h4;
   localparam logic [3:0] CMD_STBY_IMM = 4'h5;
   localparam logic [3:0] CMD_SLEEP    = 4'h6;
   localparam logic [3:0] CMD_MON_EN   = 4'h7;
   localparam logic [3:0] CMD_MON_DIS  = 4'h8;
   localparam logic [3:0] CMD_AS_EN    = 4'h9;
   localparam logic [3:0] CMD_AS_DIS   = 4'hA;

   // Power management level range and reset value.
   localparam logic [7:0] LVL_MIN   = 8'h01;
   localparam logic [7:0] LVL_MAX   = 8'hFE;
   localparam logic [7:0] LVL_RESET = 8'h80;

   // Identify words.
   localparam logic [15:0] ID83_BASE  = 16'h4000;
   localparam int unsigned APM_ID_BIT = 3;

   // Reliability attributes and their fixed thresholds (1 to 253).
   localparam int unsigned ATTR_N     = 4;
   localparam logic [7:0]  ATTR_RESET = 8'h64;
   localparam logic [7:0]  ATTR_THR [ATTR_N] = '{8'h06, 8'h1E, 8'h0A, 8'h33};

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [6:0] {
      PS_ACTIVE      = 7'h01,
      PS_PERF_IDLE   = 7'h02,
      PS_ACTIVE_IDLE = 7'h04,
      PS_LP_IDLE     = 7'h08,
      PS_STANDBY     = 7'h10,
      PS_SLEEP       = 7'h20,
      PS_WAKE        = 7'h40
   } pmh_state_t;

endpackage

// [pmh_top.sv]
// Power mode sequencer and reliability monitor with an AXI4-Lite slave.
//
// Functional notes
// - Level is 8 bits, 01h to FEh.
// - Set-features subcommands enable or disable adaptive mode.
// - Standby on timer expiry or adaptive decision.
// - Identify word 83 bit 3 shows support.
// - Identify word 86 bit 3 shows enable.
// - Identify word 91 low byte shows level.
// - After commands, enter performance idle at once.
// - Active idle parks head, 20 ms recovery.
// - Low power idle unloads heads, 300 ms recovery.
// - Entry delay chosen from recent command intervals.
// - Same selection for low power and standby.
// - Monitoring is off until host enables it.
// - Thresholds lie between 1 and 253.
// - Negative status when any value reaches threshold.
// - Thresholds are fixed, host cannot change them.
// - Higher attribute value means better health.
// - Save attributes on each non-emergency head unload.
// - Unloads by commands, reset, adaptive, timer save.
// - Auto-save also every 30 minutes.
// - Count 00h sets a 109 minute timer.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module pmh_top
   import pmh_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        hard_reset_pin_n,
   input  wire logic        emerg_unload_pin,
   output pmh_state_t       power_state,
   output logic             heads_loaded,
   output logic             spindle_on,
   output logic             attr_save,
   output logic             neg_status
);

   // Delay before entering a lower power state. Candidates run from a
   // quarter of the average interval up to twice it; the shortest one saves
   // the most energy, and is taken if its expected recovery penalty stays
   // under the bound that the level allows.
   function automatic logic [23:0] pmh_entry_delay(
      input logic [23:0] avg,
      input logic [7:0]  lvl,
      input logic [11:0] wake
   );
      logic [1:0]  sel;
      logic        found;
      logic [12:0] bound;
      sel   = 2'h3;
      found = 1'b0;
      bound = {1'b0, lvl, 4'h0} >> 3;
      for (int i = 0; i < 4; i++)
      begin
         if (!found && ({1'b0, wake} >> i) < bound)
         begin
            found = 1'b1;
            sel   = 2'(i);
         end
      end
      return 24'({1'b0, avg, 1'b0} >> (3 - sel));
   endfunction

   // AXI4-Lite slave state.
   logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic        aw_hold_reg, w_hold_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic [1:0]  bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;

   // Block state.
   pmh_state_t  state_reg, state_next;
   logic [11:0] wake_reg, wake_next;
   logic        heads_loaded_reg, heads_next, spindle_on_reg;
   logic        apm_en_reg, mon_en_reg, autosave_en_reg;
   logic [7:0]  apm_level_reg;
   logic [23:0] timer_ms_reg, idle_ms_reg, avg_ms_reg, as_ms_reg;
   logic [15:0] saves_reg;
   logic        attr_save_reg, neg_status_reg;
   logic [7:0]  attr_reg [ATTR_N];
   logic [19:0] tick_cnt_reg;
   logic        ms_tick_reg;
   logic        hr_s1, hr_s2, hr_s3, hr_lvl_reg;
   logic        em_s1, em_s2, em_s3, em_lvl_reg;

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign power_state   = state_reg;
   assign heads_loaded  = heads_loaded_reg;
   assign spindle_on    = spindle_on_reg;
   assign attr_save     = attr_save_reg;
   assign neg_status    = neg_status_reg;

   // Bus decode.
   wire aw_acc   = s_axi_awvalid & awready_reg;
   wire w_acc    = s_axi_wvalid & wready_reg;
   wire ar_acc   = s_axi_arvalid & arready_reg;
   wire wr_go    = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   wire wr_attr  = awaddr_reg[7:4] == ATTR_PAGE;
   wire wr_known = (awaddr_reg == ADDR_CMD) | wr_attr |
                   (awaddr_reg <= ADDR_THR && awaddr_reg[1:0] == 2'h0);
   wire rd_attr  = s_axi_araddr[7:4] == ATTR_PAGE;
   wire [1:0] rd_idx = s_axi_araddr[3:2];
   wire [1:0] wr_idx = awaddr_reg[3:2];

   // Host commands arrive through the command register.
   wire       cmd_fire  = wr_go & (awaddr_reg == ADDR_CMD) & wstrb_reg[0];
   wire [3:0] cmd_code  = wdata_reg[3:0];
   wire [7:0] cmd_arg   = wdata_reg[15:8];
   wire       cmd_sleep = cmd_code == CMD_SLEEP;
   wire       cmd_stby  = cmd_code == CMD_STBY || cmd_code == CMD_STBY_IMM;
   wire       lvl_ok    = cmd_arg >= LVL_MIN && cmd_arg <= LVL_MAX;
   wire       set_timer = cmd_code == CMD_IDLE || cmd_code == CMD_STBY;

   // Pins settle once the second and third stages agree.
   wire hr_evt = (hr_s2 == hr_s3) & ~hr_s3 & hr_lvl_reg;
   wire em_evt = (em_s2 == em_s3) & em_s3 & ~em_lvl_reg;

   // Adaptive entry delays, all from the same selection.
   wire [23:0] d_ai = pmh_entry_delay(avg_ms_reg, apm_level_reg, AI_WAKE);
   wire [23:0] d_lp = pmh_entry_delay(avg_ms_reg, apm_level_reg, LP_WAKE);
   wire [23:0] d_sb = pmh_entry_delay(avg_ms_reg, apm_level_reg, SPINUP_WAKE);
   wire timer_hit = timer_ms_reg != 24'h0000 && idle_ms_reg >= timer_ms_reg;

   wire unload_save = heads_loaded_reg & ~heads_next & ~em_evt;
   wire as_due      = autosave_en_reg & (as_ms_reg >= AUTOSAVE_MS);
   wire save_now    = unload_save | as_due;

   wire [15:0] id83 = ID83_BASE | (16'h0001 << APM_ID_BIT);
   wire [15:0] id86 = 16'({apm_en_reg, 3'h0});
   wire [15:0] id91 = apm_en_reg ? {8'h00, apm_level_reg} : 16'h0;
   wire [31:0] stat = {8'h00, apm_level_reg, 3'h0, heads_loaded_reg,
                       neg_status_reg, autosave_en_reg, mon_en_reg,
                       apm_en_reg, 1'b0, state_reg};
   // Thresholds are constants and have no write path.
   wire [31:0] thr  = {ATTR_THR[3], ATTR_THR[2], ATTR_THR[1], ATTR_THR[0]};

   logic [31:0] rd_data;
   logic        rd_ok;
   always_comb
   begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      if (rd_attr)
         rd_data = {24'h00_0000, attr_reg[rd_idx]};
      else
         unique case (s_axi_araddr)
            ADDR_CMD:   rd_data = 32'h0000_0000;
            ADDR_STAT:  rd_data = stat;
            ADDR_ID83:  rd_data = {16'h0000, id83};
            ADDR_ID86:  rd_data = {16'h0000, id86};
            ADDR_ID91:  rd_data = {16'h0000, id91};
            ADDR_SAVES: rd_data = {16'h0000, saves_reg};
            ADDR_THR:   rd_data = thr;
            default:    rd_ok   = 1'b0;
         endcase
   end

   // Negative status only while monitoring is on; lower is worse.
   logic any_low;
   always_comb
   begin
      any_low = 1'b0;
      for (int i = 0; i < ATTR_N; i++)
         any_low = any_low | (attr_reg[i] <= ATTR_THR[i]);
   end

   // Power state sequencing.
   always_comb
   begin
      state_next = state_reg;
      wake_next  = wake_reg;
      if (hr_evt | em_evt)
         state_next = PS_STANDBY;
      else if (state_reg == PS_SLEEP)
         state_next = PS_SLEEP;
      else if (cmd_fire && cmd_sleep)
         state_next = PS_SLEEP;
      else if (cmd_fire && cmd_stby)
         state_next = PS_STANDBY;
      else if (cmd_fire)
      begin
         unique case (state_reg)
            PS_ACTIVE_IDLE:
            begin
               state_next = PS_WAKE;
               wake_next  = AI_WAKE;
            end
            PS_LP_IDLE:
            begin
               state_next = PS_WAKE;
               wake_next  = LP_WAKE;
            end
            PS_STANDBY:
            begin
               state_next = PS_WAKE;
               wake_next  = SPINUP_WAKE;
            end
            PS_WAKE:       state_next = PS_WAKE;
            default:       state_next = PS_ACTIVE;
         endcase
      end
      else
         unique case (state_reg)
            PS_ACTIVE:      state_next = PS_PERF_IDLE;
            PS_PERF_IDLE:
               if (timer_hit)
                  state_next = PS_STANDBY;
               else if (apm_en_reg && idle_ms_reg >= d_ai)
                  state_next = PS_ACTIVE_IDLE;
            PS_ACTIVE_IDLE:
               if (timer_hit)
                  state_next = PS_STANDBY;
               else if (apm_en_reg && idle_ms_reg >= d_lp)
                  state_next = PS_LP_IDLE;
            PS_LP_IDLE:
               if (timer_hit || (apm_en_reg && idle_ms_reg >= d_sb))
                  state_next = PS_STANDBY;
            PS_WAKE:
               if (wake_reg == 12'h000)
                  state_next = PS_ACTIVE;
               else if (ms_tick_reg)
                  wake_next = wake_reg - 12'h001;
            default:        state_next = state_reg;
         endcase
   end

   // Heads stay where they were while recovering.
   assign heads_next = (state_next == PS_WAKE) ? heads_loaded_reg :
                       (state_next == PS_ACTIVE ||
                        state_next == PS_PERF_IDLE ||
                        state_next == PS_ACTIVE_IDLE);

   // Pin synchronisers.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         {hr_s1, hr_s2, hr_s3, hr_lvl_reg} <= 4'hF;
         {em_s1, em_s2, em_s3, em_lvl_reg} <= 4'h0;
      end
      else
      begin
         {hr_s1, hr_s2, hr_s3} <= {hard_reset_pin_n, hr_s1, hr_s2};
         {em_s1, em_s2, em_s3} <= {emerg_unload_pin, em_s1, em_s2};
         hr_lvl_reg <= (hr_s2 == hr_s3) ? hr_s3 : hr_lvl_reg;
         em_lvl_reg <= (em_s2 == em_s3) ? em_s3 : em_lvl_reg;
      end
   end

   // Write channel: address and data taken in either order.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         {awready_reg, wready_reg, aw_hold_reg, w_hold_reg} <= 4'hC;
         {bvalid_reg, bresp_reg, awaddr_reg} <= 11'h000;
         {wdata_reg, wstrb_reg} <= 36'h0_0000_0000;
      end
      else
      begin
         if (aw_acc)
         begin
            {aw_hold_reg, awready_reg} <= 2'h2;
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_acc)
         begin
            {w_hold_reg, wready_reg} <= 2'h2;
            {wdata_reg, wstrb_reg} <= {s_axi_wdata, s_axi_wstrb};
         end
         if (wr_go)
         begin
            {aw_hold_reg, w_hold_reg, bvalid_reg} <= 3'h1;
            bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready)
            {bvalid_reg, awready_reg, wready_reg} <= 3'h3;
      end
   end

   // Read channel: one cycle from address to data.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         {arready_reg, rvalid_reg, rresp_reg} <= 4'h8;
         rdata_reg <= 32'h0000_0000;
      end
      else if (ar_acc)
      begin
         {arready_reg, rvalid_reg} <= 2'h1;
         rdata_reg <= rd_data;
         rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
         {arready_reg, rvalid_reg} <= 2'h2;
   end

   // Millisecond enable.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         {tick_cnt_reg, ms_tick_reg} <= 21'h00_0000;
      else
      begin
         ms_tick_reg  <= tick_cnt_reg == 20'(MS_CYC - 1);
         tick_cnt_reg <= (tick_cnt_reg == 20'(MS_CYC - 1)) ? 20'h0_0000 :
                         tick_cnt_reg + 20'h0_0001;
      end
   end

   // Settings written by commands.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         {apm_en_reg, mon_en_reg, autosave_en_reg} <= 3'h0;
         apm_level_reg <= LVL_RESET;
         timer_ms_reg  <= 24'h00_0000;
      end
      else if (cmd_fire)
      begin
         if (cmd_code == CMD_APM_EN && lvl_ok)
         begin
            apm_en_reg    <= 1'b1;
            apm_level_reg <= cmd_arg;
         end
         if (cmd_code == CMD_APM_DIS)
            apm_en_reg <= 1'b0;
         if (set_timer)
            timer_ms_reg <= (cmd_arg == 8'h00) ? DEF_TIMER :
                            24'(cmd_arg) * TIMER_UNIT;
         if (cmd_code == CMD_MON_EN || cmd_code == CMD_MON_DIS)
            mon_en_reg <= cmd_code == CMD_MON_EN;
         if (cmd_code == CMD_AS_EN || cmd_code == CMD_AS_DIS)
            autosave_en_reg <= cmd_code == CMD_AS_EN;
      end
   end

   // Power state, interval measurement and attribute saving.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= PS_PERF_IDLE;
         wake_reg  <= 12'h000;
         {heads_loaded_reg, spindle_on_reg} <= 2'h3;
         {idle_ms_reg, as_ms_reg} <= 48'h0000_0000_0000;
         avg_ms_reg <= AVG_INIT;
         {saves_reg, attr_save_reg, neg_status_reg} <= 18'h0_0000;
      end
      else
      begin
         state_reg        <= state_next;
         wake_reg         <= wake_next;
         heads_loaded_reg <= heads_next;
         spindle_on_reg   <= state_next != PS_STANDBY &&
                             state_next != PS_SLEEP;
         if (cmd_fire)
         begin
            idle_ms_reg <= 24'h00_0000;
            avg_ms_reg  <= avg_ms_reg - (avg_ms_reg >> 2) +
                           (idle_ms_reg >> 2);
         end
         else if (ms_tick_reg && idle_ms_reg != 24'hFF_FFFF)
            idle_ms_reg <= idle_ms_reg + 24'h00_0001;
         if (save_now)
            as_ms_reg <= 24'h00_0000;
         else if (ms_tick_reg && !as_due)
            as_ms_reg <= as_ms_reg + 24'h00_0001;
         attr_save_reg  <= save_now;
         saves_reg      <= saves_reg + 16'(save_now);
         neg_status_reg <= mon_en_reg & any_low;
      end
   end

   // Attribute values are posted by the drive's own firmware.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         for (int i = 0; i < ATTR_N; i++)
            attr_reg[i] <= ATTR_RESET;
      else if (wr_go && wr_attr && wstrb_reg[0])
         attr_reg[wr_idx] <= wdata_reg[7:0];
   end

   chk_level_range: assert property (
      @(posedge clk) disable iff (!resetn)
      apm_en_reg |-> (apm_level_reg >= LVL_MIN && apm_level_reg <= LVL_MAX))
      else $error("Level outside its range while enabled.");

   chk_apm_onoff: assert property (
      @(posedge clk) disable iff (!resetn)
      cmd_fire && cmd_code == CMD_APM_DIS |=> !apm_en_reg ##1 !apm_en_reg)
      else $error("Disable subcommand left adaptive mode on.");

   chk_timer_standby: assert property (
      @(posedge clk) disable iff (!resetn)
      timer_hit && !cmd_fire && !hr_evt && !em_evt &&
      (state_reg == PS_PERF_IDLE || state_reg == PS_LP_IDLE)
      |=> state_reg == PS_STANDBY && !heads_loaded_reg)
      else $error("Timer expiry did not reach standby.");

   chk_id_words: assert property (
      @(posedge clk) disable iff (!resetn)
      ar_acc && s_axi_araddr == ADDR_ID91
      |=> s_axi_rvalid && s_axi_rdata[7:0] ==
          ($past(apm_en_reg) ? $past(apm_level_reg) : 8'h00))
      else $error("Identify word shows a wrong level.");

   chk_perf_after_cmd: assert property (
      @(posedge clk) disable iff (!resetn)
      state_reg == PS_ACTIVE && !cmd_fire && !hr_evt && !em_evt
      |=> state_reg == PS_PERF_IDLE ##1 heads_loaded_reg)
      else $error("No performance idle after a command.");

   chk_ai_recovery: assert property (
      @(posedge clk) disable iff (!resetn)
      state_reg == PS_ACTIVE_IDLE && cmd_fire && !cmd_sleep && !cmd_stby &&
      !hr_evt && !em_evt
      |=> state_reg == PS_WAKE && wake_reg == AI_WAKE && idle_ms_reg == 0)
      else $error("Wake from active idle not loaded with 20 ms.");

   chk_save_on_unload: assert property (
      @(posedge clk) disable iff (!resetn)
      heads_loaded_reg && !heads_next && !em_evt |=> attr_save_reg)
      else $error("Head unload did not save attributes.");

   chk_no_emerg_save: assert property (
      @(posedge clk) disable iff (!resetn)
      em_evt && !as_due |=> !attr_save_reg)
      else $error("Emergency unload saved attributes.");

   chk_neg_status: assert property (
      @(posedge clk) disable iff (!resetn)
      mon_en_reg && attr_reg[0] <= ATTR_THR[0] |=> neg_status_reg)
      else $error("Low attribute not reported as negative.");

   chk_monitor_off: assert property (
      @(posedge clk) disable iff (!resetn)
      !mon_en_reg |=> !neg_status_reg)
      else $error("Negative status while monitoring is off.");

endmodule

// [tb_top.sv]
// Self-checking bench for the power mode and health monitor.
`timescale 1ns/1ps
module tb_top;
   import pmh_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, emerg_req = 1'b0, hrst_req = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready;
   logic rvalid, heads_loaded, spindle_on, attr_save, neg_status;
   logic hard_reset_pin_n, emerg_unload_pin;
   logic [1:0] bresp, rresp, br;
   pmh_state_t power_state;
   int n_mismatch = 0, checks_done = 0, n_save = 0;
   pmh_top #(.MS_CYC(1)) u_pmh_top (.clk(clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .hard_reset_pin_n(hard_reset_pin_n), .emerg_unload_pin(emerg_unload_pin),
      .power_state(power_state), .heads_loaded(heads_loaded),
      .spindle_on(spindle_on), .attr_save(attr_save), .neg_status(neg_status));
   pmh_host_pins u_pmh_host_pins (.clk(clk), .emerg_req(emerg_req),
      .hrst_req(hrst_req), .hard_reset_pin_n(hard_reset_pin_n),
      .emerg_unload_pin(emerg_unload_pin));
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (attr_save === 1'b1) n_save++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      br = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
   endtask
   // Waking from standby scales with MS_CYC, so the wait is generous.
   task automatic wait_st(input pmh_state_t s);
      for (int i = 0; i < 9000 && power_state !== s; i++) @(posedge clk);
      chk({25'h0, power_state}, {25'h0, s});
   endtask
   task automatic print_verdict();
      $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      n_mismatch++;
      print_verdict();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(ADDR_ID83); chk(d, 32'h0000_4008);
      rd(ADDR_ID86); chk(d, 32'h0000_0000);
      rd(ADDR_STAT); chk(d & 32'h00FF_0200, 32'h0080_0000);
      wr(ADDR_CMD, 32'h0000_FE01);
      rd(ADDR_ID86); chk(d, 32'h0000_0008);
      rd(ADDR_ID91); chk(d & 32'h0000_00FF, 32'h0000_00FE);
      wr(ADDR_CMD, 32'h0000_0002);
      rd(ADDR_ID86); chk(d, 32'h0000_0000);
      rd(ADDR_THR); chk(d, 32'h330A_1E06);
      wr(ADDR_THR, 32'h0000_0000);
      chk({30'h0, br}, {30'h0, RESP_OKAY});
      rd(ADDR_THR); chk(d, 32'h330A_1E06);
      rd(8'h1C); chk({30'h0, rresp}, {30'h0, RESP_SLVERR});
      wr(8'h1C, 32'h0000_0000);
      chk({30'h0, br}, {30'h0, RESP_SLVERR});
      wr(8'h20, 32'h0000_0006);
      repeat (3) @(posedge clk);
      chk({31'h0, neg_status}, 32'h0000_0000);
      wr(ADDR_CMD, 32'h0000_0007);
      repeat (3) @(posedge clk);
      chk({31'h0, neg_status}, 32'h0000_0001);
      wr(ADDR_CMD, 32'h0000_0008);
      repeat (3) @(posedge clk);
      chk({31'h0, neg_status}, 32'h0000_0000);
      wr(ADDR_CMD, 32'h0000_0009);
      rd(ADDR_STAT); chk(d & 32'h0000_0E00, 32'h0000_0400);
      wr(ADDR_CMD, 32'h0000_0007);
      repeat (3) @(posedge clk);
      chk({31'h0, neg_status}, 32'h0000_0001);
      wr(8'h20, 32'h0000_0007);
      repeat (3) @(posedge clk);
      chk({31'h0, neg_status}, 32'h0000_0000);
      wr(ADDR_CMD, 32'h0000_000B);
      wait_st(PS_PERF_IDLE);
      emerg_req <= 1'b1;
      @(posedge clk);
      emerg_req <= 1'b0;
      wait_st(PS_STANDBY);
      rd(ADDR_SAVES); chk(d, 32'h0000_0000);
      wr(ADDR_CMD, 32'h0000_000C);
      wait_st(PS_PERF_IDLE);
      wr(ADDR_CMD, 32'h0000_0005);
      wait_st(PS_STANDBY);
      chk({31'h0, heads_loaded}, 32'h0000_0000);
      rd(ADDR_SAVES); chk(d, 32'h0000_0001);
      chk(n_save, 32'h0000_0001);
      wr(ADDR_CMD, 32'h0000_0006);
      wait_st(PS_SLEEP);
      hrst_req <= 1'b1;
      @(posedge clk);
      hrst_req <= 1'b0;
      wait_st(PS_STANDBY);
      wr(ADDR_CMD, 32'h0000_0103);
      wait_st(PS_PERF_IDLE);
      wait_st(PS_STANDBY);
      rd(ADDR_SAVES); chk(d, 32'h0000_0002);
      wr(ADDR_CMD, 32'h0000_1001);
      wait_st(PS_ACTIVE_IDLE);
      chk({31'h0, heads_loaded}, 32'h0000_0001);
      wr(ADDR_CMD, 32'h0000_000B);
      chk({25'h0, power_state}, {25'h0, PS_WAKE});
      repeat (19) @(posedge clk);
      chk({25'h0, power_state}, {25'h0, PS_WAKE});
      repeat (2) @(posedge clk);
      chk({25'h0, power_state}, {25'h0, PS_ACTIVE});
      wait_st(PS_LP_IDLE);
      chk({30'h0, heads_loaded, spindle_on}, 32'h0000_0001);
      wait_st(PS_STANDBY);
      chk({31'h0, spindle_on}, 32'h0000_0000);
      rd(ADDR_SAVES); chk(d, 32'h0000_0003);
      chk(n_save, 32'h0000_0003);
      print_verdict();
   end
endmodule
